/* File: rtl/aasf_regs.sv */
// status and configuration register bank of a stereo amplifier
// assumes detector inputs arrive from other clock domains or pins,
// and a single-cycle strobe register port on core_clk_in
`timescale 1ns/1ns

// Function
// - halt event latches bit 4 until read
// - halt bit reads one once, read clears
// - bit 2 shows both serial clocks missing
// - bit 1 shows live resync status
// - clock error latches bit 0, read clears
// - bit 1 left analog mute, zero muted
// - bit 0 right analog mute, zero muted
// - bit 5 shows general pin two level
// - bit 4 shows external mute pin level
// - bit 3 shows general pin zero level
// - bit 4 shows left auto mute
// - bit 0 shows right auto mute
// - amplitude mode bit 0, reset zero
// - gain bits select 0/-6 dB, reset zero
module aasf_regs #(
    parameter int unsigned SYNC_STAGES = 2   // synchroniser depth
) (
    input  wire logic       core_clk_in,           // system clock
    input  wire logic       sys_rst_in,            // sync reset, high
    input  wire logic [8:0] reg_addr_in,           // page and offset
    input  wire logic [7:0] reg_wdata_in,          // write data
    input  wire logic       reg_write_in,          // write strobe
    input  wire logic       reg_read_in,           // read strobe
    output logic      [7:0] reg_rdata_out,         // read data
    input  wire logic       master_clock_halt_in,  // halt detector level
    input  wire logic       clock_error_in,        // clock error level
    input  wire logic       serial_clocks_missing_in,
    input  wire logic       clock_resync_active_in,
    input  wire logic       left_analog_mute_state_in,  // high = unmute
    input  wire logic       right_analog_mute_state_in, // high = unmute
    input  wire logic       general_pin_two_in,
    input  wire logic       mute_pin_in,
    input  wire logic       general_pin_zero_in,
    input  wire logic       left_auto_mute_flag_in,
    input  wire logic       right_auto_mute_flag_in,
    output logic            output_amplitude_mode_out, // 1 = common mode
    output logic            left_analog_gain_out,      // 1 = -6 dB
    output logic            right_analog_gain_out,     // 1 = -6 dB
    output logic            irq_out                    // level interrupt
);

    // number of asynchronous inputs passing the synchroniser
    localparam int unsigned N_IN    = 11;
    // width of the interrupt status and enable registers
    localparam int unsigned IRQ_W_L = aasf_pkg::IRQ_W;

    // only a two-flop synchroniser is built; refuse other depths
    if (SYNC_STAGES != 2) begin : g_bad_sync
        $error("aasf_regs: SYNC_STAGES must be 2");
    end

    // whole state of the block
    typedef struct packed {
        logic [N_IN-1:0] sync1;       // first synchroniser stage
        logic [N_IN-1:0] sync2;       // second synchroniser stage
        logic            halt_prev;   // halt level, one cycle old
        logic            err_prev;    // error level, one cycle old
        logic            halt_latch;  // latched master clock halt
        logic            err_latch;   // latched clock error
        logic            ampl_mode;   // output amplitude mode
        logic            left_gain;   // left analog gain
        logic            right_gain;  // right analog gain
        logic [IRQ_W_L-1:0] irq_stat; // sticky interrupt status
        logic [IRQ_W_L-1:0] irq_en;   // interrupt enables
        logic [7:0]      rdata;       // registered read data
    } aasf_state_s;

    aasf_state_s st;       // registered state
    aasf_state_s next_st;  // next state

    // synchroniser input vector in a fixed order
    logic [N_IN-1:0] raw_in;
    assign raw_in = {master_clock_halt_in, clock_error_in,
                     serial_clocks_missing_in, clock_resync_active_in,
                     left_analog_mute_state_in, right_analog_mute_state_in,
                     general_pin_two_in, mute_pin_in, general_pin_zero_in,
                     left_auto_mute_flag_in, right_auto_mute_flag_in};

    // synchronised levels, named
    logic s_halt, s_err, s_miss, s_resync, s_lmute, s_rmute;
    logic s_pin2, s_mpin, s_pin0, s_lam, s_ram;
    assign {s_halt, s_err, s_miss, s_resync, s_lmute, s_rmute,
            s_pin2, s_mpin, s_pin0, s_lam, s_ram} = st.sync2;

    // address decode shared by read and write paths
    function automatic logic hit(input logic [8:0] a, input logic [8:0] o);
        hit = (a == o);
    endfunction : hit

    // rising edges of the synchronised event levels
    logic halt_rise;
    logic err_rise;
    assign halt_rise = s_halt & ~st.halt_prev;
    assign err_rise  = s_err & ~st.err_prev;

    // read strobes that clear the latched clock fault bits
    logic cff_read;
    assign cff_read = reg_read_in &
                      hit(reg_addr_in, aasf_pkg::OFF_CLOCK_FAULT_FLAGS);

    // next-state logic
    always_comb begin
        next_st = st;
        next_st.sync1 = raw_in;
        next_st.sync2 = st.sync1;
        next_st.halt_prev = s_halt;
        next_st.err_prev  = s_err;
        // latched bits: a new event wins over a clearing read
        if (halt_rise) begin
            next_st.halt_latch = 1'b1;
        end else if (cff_read) begin
            next_st.halt_latch = 1'b0;
        end
        if (err_rise) begin
            next_st.err_latch = 1'b1;
        end else if (cff_read) begin
            next_st.err_latch = 1'b0;
        end
        // interrupt status: clear by write of one, set wins
        if (reg_write_in && hit(reg_addr_in, aasf_pkg::OFF_IRQ_CLEAR)) begin
            next_st.irq_stat = st.irq_stat & ~reg_wdata_in[IRQ_W_L-1:0];
        end
        if (halt_rise) begin
            next_st.irq_stat[aasf_pkg::IRQ_HALT] = 1'b1;
        end
        if (err_rise) begin
            next_st.irq_stat[aasf_pkg::IRQ_ERROR] = 1'b1;
        end
        // register writes
        if (reg_write_in) begin
            if (hit(reg_addr_in, aasf_pkg::OFF_OUTPUT_AMPL_SEL)) begin
                next_st.ampl_mode =
                    reg_wdata_in[aasf_pkg::BIT_AMPL_MODE];
            end
            if (hit(reg_addr_in, aasf_pkg::OFF_ANALOG_GAIN_SEL)) begin
                next_st.left_gain =
                    reg_wdata_in[aasf_pkg::BIT_LEFT_GAIN];
                next_st.right_gain =
                    reg_wdata_in[aasf_pkg::BIT_RIGHT_GAIN];
            end
            if (hit(reg_addr_in, aasf_pkg::OFF_IRQ_ENABLE)) begin
                next_st.irq_en = reg_wdata_in[IRQ_W_L-1:0];
            end
        end
        // read mux, data valid the cycle after the strobe
        next_st.rdata = 8'h00;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                aasf_pkg::OFF_CLOCK_FAULT_FLAGS: begin
                    // latched bits show pending events, then clear
                    next_st.rdata[aasf_pkg::BIT_MCLK_HALT] =
                        st.halt_latch;
                    next_st.rdata[aasf_pkg::BIT_CLK_MISSING] =
                        s_miss;
                    next_st.rdata[aasf_pkg::BIT_RESYNC] =
                        s_resync;
                    next_st.rdata[aasf_pkg::BIT_CLK_ERROR] =
                        st.err_latch;
                end
                aasf_pkg::OFF_ANALOG_MUTE_MON: begin
                    next_st.rdata[aasf_pkg::BIT_LEFT_MUTE]  = s_lmute;
                    next_st.rdata[aasf_pkg::BIT_RIGHT_MUTE] = s_rmute;
                end
                aasf_pkg::OFF_PIN_LEVEL_READBACK: begin
                    next_st.rdata[aasf_pkg::BIT_PIN_TWO]  = s_pin2;
                    next_st.rdata[aasf_pkg::BIT_MUTE_PIN] = s_mpin;
                    next_st.rdata[aasf_pkg::BIT_PIN_ZERO] = s_pin0;
                end
                aasf_pkg::OFF_AUTO_MUTE_FLAGS: begin
                    next_st.rdata[aasf_pkg::BIT_LEFT_AMUTE]  = s_lam;
                    next_st.rdata[aasf_pkg::BIT_RIGHT_AMUTE] = s_ram;
                end
                aasf_pkg::OFF_OUTPUT_AMPL_SEL: begin
                    next_st.rdata[aasf_pkg::BIT_AMPL_MODE] = st.ampl_mode;
                end
                aasf_pkg::OFF_ANALOG_GAIN_SEL: begin
                    next_st.rdata[aasf_pkg::BIT_LEFT_GAIN]  = st.left_gain;
                    next_st.rdata[aasf_pkg::BIT_RIGHT_GAIN] = st.right_gain;
                end
                aasf_pkg::OFF_IRQ_STATUS: begin
                    next_st.rdata[IRQ_W_L-1:0] = st.irq_stat;
                end
                aasf_pkg::OFF_IRQ_ENABLE: begin
                    next_st.rdata[IRQ_W_L-1:0] = st.irq_en;
                end
                default: begin
                    // unmapped and write-only addresses read zero
                    next_st.rdata = aasf_pkg::READ_UNMAPPED;
                end
            endcase
        end
    end

    // state register with synchronous reset
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st            <= '0;
            st.ampl_mode  <= aasf_pkg::RST_OUTPUT_AMPL[0];
            st.left_gain  <= aasf_pkg::RST_ANALOG_GAIN[4];
            st.right_gain <= aasf_pkg::RST_ANALOG_GAIN[0];
            st.irq_en     <= aasf_pkg::RST_IRQ_ENABLE;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops; irq_out is the OR of status AND enable flops
    assign reg_rdata_out             = st.rdata;
    // the host must program dividers itself in common mode with PLL
    assign output_amplitude_mode_out = st.ampl_mode;
    assign left_analog_gain_out      = st.left_gain;
    assign right_analog_gain_out     = st.right_gain;
    assign irq_out                   = |(st.irq_stat & st.irq_en);

    // a halt edge is reported in the latched bit on the next cycle
    property p_halt_latch;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        halt_rise |=> st.halt_latch;
    endproperty
    a_halt_latch: assert property (p_halt_latch)
        else $error("halt edge not latched");

    // a clearing read with no new halt leaves the bit low
    property p_halt_clear;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        cff_read && !halt_rise |=> !st.halt_latch;
    endproperty
    a_halt_clear: assert property (p_halt_clear)
        else $error("halt bit not cleared by read");

    // read data of the fault register carries the latched halt
    property p_halt_read;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        cff_read |=> reg_rdata_out[4] == $past(st.halt_latch);
    endproperty
    a_halt_read: assert property (p_halt_read)
        else $error("halt read value wrong");

    // missing clocks bit follows the synchronised level
    property p_missing;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        cff_read |=> reg_rdata_out[2] == $past(s_miss);
    endproperty
    a_missing: assert property (p_missing)
        else $error("clock missing bit wrong");

    // resync bit is live
    property p_resync;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        cff_read |=> reg_rdata_out[1] == $past(s_resync);
    endproperty
    a_resync: assert property (p_resync)
        else $error("resync bit wrong");

    // error edge coinciding with a read still latches
    property p_err_keep;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        err_rise && cff_read |=> st.err_latch ##1 1'b1;
    endproperty
    a_err_keep: assert property (p_err_keep)
        else $error("clock error lost on read");

    // clock error latch clears after a read without a new error
    property p_err_clear;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        cff_read && !err_rise |=> !st.err_latch;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("clock error not cleared");

    // mute monitor read returns both channel states
    property p_mute_mon;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        reg_read_in && reg_addr_in == aasf_pkg::OFF_ANALOG_MUTE_MON
        |=> reg_rdata_out == {6'h00, $past(s_lmute), $past(s_rmute)};
    endproperty
    a_mute_mon: assert property (p_mute_mon)
        else $error("mute monitor read wrong");

    // gain write shows on the outputs next cycle
    property p_gain;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        reg_write_in && reg_addr_in == aasf_pkg::OFF_ANALOG_GAIN_SEL
        |=> left_analog_gain_out == $past(reg_wdata_in[4]) &&
            right_analog_gain_out == $past(reg_wdata_in[0]);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain bits not written");

    // an error edge is reported in the latched bit on the next cycle
    property p_err_latch;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        err_rise |=> st.err_latch;
    endproperty
    a_err_latch: assert property (p_err_latch)
        else $error("clock error edge not latched");

    // read data of the fault register carries the latched error
    property p_err_read;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        cff_read |=> reg_rdata_out[0] == $past(st.err_latch);
    endproperty
    a_err_read: assert property (p_err_read)
        else $error("clock error read value wrong");

    // halt edge coinciding with a read still latches
    property p_halt_keep;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        halt_rise && cff_read |=> st.halt_latch;
    endproperty
    a_halt_keep: assert property (p_halt_keep)
        else $error("halt lost on read");

    // latched halt stays set until a read of the fault register
    property p_halt_hold;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        st.halt_latch && !cff_read |=> st.halt_latch;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt bit dropped without read");

    // latched error stays set until a read of the fault register
    property p_err_hold;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        st.err_latch && !cff_read |=> st.err_latch;
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("clock error dropped without read");

    // pin readback returns the three synchronised pin levels
    property p_pin_level;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        reg_read_in && reg_addr_in == aasf_pkg::OFF_PIN_LEVEL_READBACK
        |=> reg_rdata_out == {2'b00, $past(s_pin2), $past(s_mpin),
                              $past(s_pin0), 3'b000};
    endproperty
    a_pin_level: assert property (p_pin_level)
        else $error("pin level read wrong");

    // auto mute read returns both channel flags
    property p_auto_mute;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        reg_read_in && reg_addr_in == aasf_pkg::OFF_AUTO_MUTE_FLAGS
        |=> reg_rdata_out == {3'b000, $past(s_lam), 3'b000, $past(s_ram)};
    endproperty
    a_auto_mute: assert property (p_auto_mute)
        else $error("auto mute read wrong");

    // amplitude mode write shows on the output next cycle
    property p_ampl_write;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        reg_write_in && reg_addr_in == aasf_pkg::OFF_OUTPUT_AMPL_SEL
        |=> output_amplitude_mode_out == $past(reg_wdata_in[0]);
    endproperty
    a_ampl_write: assert property (p_ampl_write)
        else $error("amplitude mode not written");

    // amplitude mode read returns the stored bit only
    property p_ampl_read;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        reg_read_in && reg_addr_in == aasf_pkg::OFF_OUTPUT_AMPL_SEL
        |=> reg_rdata_out == {7'h00, $past(st.ampl_mode)};
    endproperty
    a_ampl_read: assert property (p_ampl_read)
        else $error("amplitude mode read wrong");

    // gain read returns both stored gain bits in place
    property p_gain_read;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        reg_read_in && reg_addr_in == aasf_pkg::OFF_ANALOG_GAIN_SEL
        |=> reg_rdata_out == {3'b000, $past(st.left_gain), 3'b000,
                              $past(st.right_gain)};
    endproperty
    a_gain_read: assert property (p_gain_read)
        else $error("gain read wrong");

    // control outputs come out of reset low
    property p_rst_values;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        $fell(sys_rst_in) |-> !output_amplitude_mode_out &&
            !left_analog_gain_out && !right_analog_gain_out;
    endproperty
    a_rst_values: assert property (p_rst_values)
        else $error("control bits not cleared by reset");

endmodule : aasf_regs

/* File: rtl/aasf_pkg.sv */
// package for the amplifier status flag register bank
// assumes an 8-bit register port with an address that carries the page
package aasf_pkg;
    // address width: bit 8 selects the page, bits 7:0 the register
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 8;

    // page-zero register offsets
    localparam logic [8:0] OFF_CLOCK_FAULT_FLAGS  = 9'h0_5F;
    localparam logic [8:0] OFF_ANALOG_MUTE_MON    = 9'h0_6C;
    localparam logic [8:0] OFF_PIN_LEVEL_READBACK = 9'h0_77;
    localparam logic [8:0] OFF_AUTO_MUTE_FLAGS    = 9'h0_78;
    // page-one register offsets
    localparam logic [8:0] OFF_OUTPUT_AMPL_SEL    = 9'h1_01;
    localparam logic [8:0] OFF_ANALOG_GAIN_SEL    = 9'h1_02;
    // interrupt registers on page one
    localparam logic [8:0] OFF_IRQ_STATUS         = 9'h1_F0;
    localparam logic [8:0] OFF_IRQ_CLEAR          = 9'h1_F1;
    localparam logic [8:0] OFF_IRQ_ENABLE         = 9'h1_F2;

    // clock fault flag fields
    localparam int unsigned BIT_MCLK_HALT    = 4;
    localparam int unsigned BIT_CLK_MISSING  = 2;
    localparam int unsigned BIT_RESYNC       = 1;
    localparam int unsigned BIT_CLK_ERROR    = 0;
    // analog mute monitor fields
    localparam int unsigned BIT_LEFT_MUTE    = 1;
    localparam int unsigned BIT_RIGHT_MUTE   = 0;
    // pin level readback fields
    localparam int unsigned BIT_PIN_TWO      = 5;
    localparam int unsigned BIT_MUTE_PIN     = 4;
    localparam int unsigned BIT_PIN_ZERO     = 3;
    // auto mute flag fields
    localparam int unsigned BIT_LEFT_AMUTE   = 4;
    localparam int unsigned BIT_RIGHT_AMUTE  = 0;
    // page-one fields
    localparam int unsigned BIT_AMPL_MODE    = 0;
    localparam int unsigned BIT_LEFT_GAIN    = 4;
    localparam int unsigned BIT_RIGHT_GAIN   = 0;
    // interrupt status fields
    localparam int unsigned IRQ_HALT         = 0;
    localparam int unsigned IRQ_ERROR        = 1;
    localparam int unsigned IRQ_W            = 2;

    // reset values
    localparam logic [7:0] RST_OUTPUT_AMPL   = 8'h00;
    localparam logic [7:0] RST_ANALOG_GAIN   = 8'h00;
    localparam logic [1:0] RST_IRQ_ENABLE    = 2'h0;
    localparam logic [7:0] READ_UNMAPPED     = 8'h00;
endpackage : aasf_pkg

/* File: tb/tb_top.sv */
// self-checking bench for the amplifier status flag register bank
// assumes aasf_pkg and aasf_regs are compiled first; one 100 MHz clock
`timescale 1ns/1ns

module tb_top;
    logic        core_clk;     // system clock
    logic        sys_rst;      // synchronous reset, high
    logic [8:0]  reg_addr;     // page and offset
    logic [7:0]  reg_wdata;    // write data
    logic        reg_write;    // write strobe
    logic        reg_read;     // read strobe
    logic [7:0]  reg_rdata;    // read data from the bank
    logic [10:0] lv;           // detector and pin levels
    logic        ampl_mode;    // amplitude mode output
    logic        gain_left;    // left gain output
    logic        gain_right;   // right gain output
    logic        irq;          // level interrupt
    logic [7:0]  got;          // last read result
    int          bad_count;    // mismatches seen
    int          cmp_count;    // comparisons made
    int          cycles;       // timeout counter

    // clock: 10 ns period
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    aasf_regs aasf_regs_inst (
        .core_clk_in                (core_clk),
        .sys_rst_in                 (sys_rst),
        .reg_addr_in                (reg_addr),
        .reg_wdata_in               (reg_wdata),
        .reg_write_in               (reg_write),
        .reg_read_in                (reg_read),
        .reg_rdata_out              (reg_rdata),
        .master_clock_halt_in       (lv[10]),
        .clock_error_in             (lv[9]),
        .serial_clocks_missing_in   (lv[8]),
        .clock_resync_active_in     (lv[7]),
        .left_analog_mute_state_in  (lv[6]),
        .right_analog_mute_state_in (lv[5]),
        .general_pin_two_in         (lv[4]),
        .mute_pin_in                (lv[3]),
        .general_pin_zero_in        (lv[2]),
        .left_auto_mute_flag_in     (lv[1]),
        .right_auto_mute_flag_in    (lv[0]),
        .output_amplitude_mode_out  (ampl_mode),
        .left_analog_gain_out       (gain_left),
        .right_analog_gain_out      (gain_right),
        .irq_out                    (irq)
    );

    // verdict and end of run
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    // compare one byte
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp8

    // compare one output bit
    task automatic cmp1(input logic g, input logic e);
        cmp8({7'h00, g}, {7'h00, e});
    endtask : cmp1

    // wait n edges, then step off the edge
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : idle

    // one-cycle write; caller stands just after an edge
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    // one-cycle read; data taken in the following cycle
    task automatic rd_raw(input logic [8:0] a);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        got = reg_rdata;
    endtask : rd_raw

    // read and compare
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        rd_raw(a);
        cmp8(got, e);
    endtask : rd

    // drive a level pattern and read all four page-zero status registers
    task automatic chk_status(input logic [10:0] p);
        lv <= p;
        idle(3);
        rd(9'h0_5F, {5'h00, p[8], p[7], 1'b0});
        rd(9'h0_6C, {6'h00, p[6], p[5]});
        rd(9'h0_77, {2'h0, p[4], p[3], p[2], 3'h0});
        rd(9'h0_78, {3'h0, p[1], 3'h0, p[0]});
    endtask : chk_status

    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            wrap_up();
        end
    end

    // main sequence
    initial begin
        bad_count = 0;
        cmp_count = 0;
        cycles    = 0;
        sys_rst   = 1'b1;
        reg_addr  = 9'h000;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read  = 1'b0;
        lv        = 11'h000;
        got       = 8'h00;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        idle(4);
        // values after reset
        rd(9'h1_01, 8'h00);
        rd(9'h1_02, 8'h00);
        cmp1(ampl_mode, 1'b0);
        cmp1(gain_left, 1'b0);
        cmp1(gain_right, 1'b0);
        cmp1(irq, 1'b0);
        // live status levels, several patterns
        chk_status(11'h1FF);
        chk_status(11'h0AA);
        chk_status(11'h155);
        chk_status(11'h000);
        // read data stands one cycle only
        idle(1);
        cmp8(reg_rdata, 8'h00);
        // halt latches after the level goes away, read clears
        lv <= 11'h400;
        idle(8);
        lv <= 11'h000;
        idle(4);
        rd(9'h0_5F, 8'h10);
        rd(9'h0_5F, 8'h00);
        // clock error latches, read clears
        lv <= 11'h200;
        idle(6);
        lv <= 11'h000;
        idle(4);
        rd(9'h0_5F, 8'h01);
        rd(9'h0_5F, 8'h00);
        // halt edge lands on the clearing read
        lv <= 11'h400;
        idle(2);
        rd_raw(9'h0_5F);
        cmp8(got, 8'h00);
        rd(9'h0_5F, 8'h10);
        lv <= 11'h000;
        // page-one control bits
        wr(9'h1_01, 8'hFF);
        rd(9'h1_01, 8'h01);
        cmp1(ampl_mode, 1'b1);
        wr(9'h1_02, 8'hFF);
        rd(9'h1_02, 8'h11);
        cmp1(gain_left, 1'b1);
        cmp1(gain_right, 1'b1);
        wr(9'h1_02, 8'h10);
        cmp1(gain_left, 1'b1);
        cmp1(gain_right, 1'b0);
        wr(9'h1_01, 8'h00);
        wr(9'h1_02, 8'h01);
        rd(9'h1_02, 8'h01);
        cmp1(ampl_mode, 1'b0);
        cmp1(gain_left, 1'b0);
        cmp1(gain_right, 1'b1);
        // read-only and unmapped places ignore writes
        wr(9'h0_6C, 8'hFF);
        rd(9'h0_6C, 8'h00);
        wr(9'h0_AA, 8'hFF);
        rd(9'h0_AA, 8'h00);
        // interrupt: clear leftovers, enable, raise, clear
        wr(9'h1_F1, 8'h03);
        rd(9'h1_F0, 8'h00);
        rd(9'h1_F1, 8'h00);
        wr(9'h1_F2, 8'h03);
        rd(9'h1_F2, 8'h03);
        lv <= 11'h200;
        idle(5);
        cmp1(irq, 1'b1);
        rd(9'h1_F0, 8'h02);
        lv <= 11'h000;
        wr(9'h1_F1, 8'h02);
        idle(1);
        cmp1(irq, 1'b0);
        rd(9'h0_5F, 8'h01);
        // masked halt sets status without the interrupt
        wr(9'h1_F2, 8'h02);
        lv <= 11'h400;
        idle(5);
        cmp1(irq, 1'b0);
        rd(9'h1_F0, 8'h01);
        lv <= 11'h000;
        wr(9'h1_F1, 8'h01);
        rd(9'h1_F0, 8'h00);
        rd(9'h0_5F, 8'h10);
        // second reset in mid-run brings the control bits back
        wr(9'h1_01, 8'h01);
        wr(9'h1_02, 8'h11);
        sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        idle(3);
        cmp1(ampl_mode, 1'b0);
        cmp1(gain_left, 1'b0);
        cmp1(gain_right, 1'b0);
        rd(9'h1_02, 8'h00);
        wrap_up();
    end
endmodule : tb_top
